/* include/mspi_defs.vh */
// Purpose: constants for the serial port in master SPI mode
// Assumes: 20 MHz system clock
// Notes: mode select value 2'b11 selects master SPI operation
`ifndef MSPI_DEFS_VH
`define MSPI_DEFS_VH
`define MSPI_MODE_SEL 2'h3
`define MSPI_DIV_W 12
`define MSPI_DIV_RESET 12'h000
`define MSPI_FRAME_BITS 4'h8
`define MSPI_BITCNT_W 4
`define MSPI_IDLE_LINE 1'b1
`define MSPI_FIFO_DEPTH 4
`define MSPI_FIFO_AW 2
`endif

/* logic/mspi_fifo.v */
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two equal to 2**AW
// Notes: full and empty come from a separate occupancy count
`timescale 1ns/1ps
module mspi_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Fill side
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   // Drain side
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire [AW:0] level_o
);
   reg [WIDTH-1:0] mem_r [0:DEPTH-1];
   reg [AW-1:0] wr_ptr_r;
   reg [AW-1:0] rd_ptr_r;
   reg [AW:0] count_r;
   wire push;
   wire pop;
   integer i;

   // Handshake terms
   assign in_ready_o = (count_r != DEPTH[AW:0]);
   assign out_valid_o = (count_r != {(AW+1){1'b0}});
   assign push = in_valid_i & in_ready_o;
   assign pop = out_valid_o & out_ready_i;
   assign out_data_o = mem_r[rd_ptr_r];
   assign level_o = count_r;

   // Storage and pointers
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         wr_ptr_r <= {AW{1'b0}};
         rd_ptr_r <= {AW{1'b0}};
         count_r <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_r[i] <= {WIDTH{1'b0}};
         end
      end else begin
         if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (push && !pop) begin
            count_r <= count_r + 1'b1;
         end else if (pop && !push) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule

/* logic/mspi_baud_gen.v */
// Purpose: baud tick generator for the transfer clock
// Assumes: divisor may change at any time
// Notes: one tick every divisor+1 cycles, two ticks per bit
`timescale 1ns/1ps
`include "mspi_defs.vh"
module mspi_baud_gen #(
   parameter DIV_W = 12
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Control
   input wire run_i,
   input wire [DIV_W-1:0] divisor_i,
   // Half-bit tick
   output reg tick_o
);
   reg [DIV_W-1:0] cnt_r;

   // Down counter reloaded with divisor
   always @(posedge ref_clk_i) begin
      if (rst_i || !run_i) begin
         cnt_r <= {DIV_W{1'b0}};
         tick_o <= 1'b0;
      end else if (cnt_r == {DIV_W{1'b0}}) begin
         cnt_r <= divisor_i;
         tick_o <= 1'b1;
      end else begin
         cnt_r <= cnt_r - 1'b1;
         tick_o <= 1'b0;
      end
   end
endmodule

/* logic/mspi_master.v */
// Purpose: serial port core running as a three-wire SPI master
// Assumes: software side on ref_clk_i; data in pin is asynchronous
// Notes: transmit queue is a FIFO, receive side a two-deep buffer
`timescale 1ns/1ps
`include "mspi_defs.vh"
module mspi_master #(
   parameter DIV_W = 12,
   parameter FIFO_DEPTH = 4,
   parameter FIFO_AW = 2
) (
   // Clock and reset
   input wire ref_clk_i,
   input wire rst_i,
   // Configuration
   input wire [1:0] operating_mode_select_i,
   input wire transmitter_enable_i,
   input wire receiver_enable_i,
   input wire clock_pin_direction_i,
   input wire clock_polarity_select_i,
   input wire clock_phase_select_i,
   input wire bit_order_select_i,
   input wire [3:0] baud_divisor_high_i,
   input wire [7:0] baud_divisor_low_i,
   // Transmit data write
   input wire tx_write_i,
   input wire [7:0] tx_data_i,
   output wire tx_ready_o,
   // Receive data read
   input wire rx_read_i,
   output reg [7:0] rx_data_o,
   output wire rx_valid_o,
   // Status
   output wire master_serial_peripheral_mode_o,
   output reg tx_complete_o,
   output wire framing_error_flag_o,
   output wire overrun_flag_o,
   output wire parity_error_flag_o,
   output wire busy_o,
   // Serial pins
   output reg transfer_clock_pin_o,
   output wire transfer_clock_pin_oe_o,
   output reg data_out_o,
   output wire data_out_oe_o,
   input wire data_in_i
);
   // Controller states
   localparam ST_IDLE = 2'b00;
   localparam ST_LEAD = 2'b01;
   localparam ST_TRAIL = 2'b10;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg [7:0] tx_shift_r;
   reg [7:0] rx_shift_r;
   reg [`MSPI_BITCNT_W-1:0] bit_cnt_r;
   reg din_meta_r;
   reg din_sync_r;
   reg cpol_r;
   reg cpha_r;
   reg [7:0] rx_hold_r;
   reg rx_hold_valid_r;
   reg rx_valid_r;
   wire spi_mode;
   wire [DIV_W-1:0] divisor;
   wire tick;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   wire fifo_pop;
   wire frame_done;
   wire mode_changed;
   wire rx_push;
   wire out_bit;

   // Mode decode
   assign spi_mode = (operating_mode_select_i == `MSPI_MODE_SEL);
   assign master_serial_peripheral_mode_o = spi_mode;
   assign divisor = {baud_divisor_high_i, baud_divisor_low_i};

   // Error flags unused
   assign framing_error_flag_o = 1'b0;
   assign overrun_flag_o = 1'b0;
   assign parity_error_flag_o = 1'b0;

   // Pins driven only when enabled; clock direction set by software
   assign transfer_clock_pin_oe_o = spi_mode & clock_pin_direction_i;
   assign data_out_oe_o = spi_mode & transmitter_enable_i;

   // Transmit buffer
   mspi_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH),
      .AW(FIFO_AW)
   ) u_tx_fifo (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .in_valid_i(tx_write_i & spi_mode & transmitter_enable_i),
      .in_ready_o(fifo_in_ready),
      .in_data_i(tx_data_i),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(fifo_pop),
      .out_data_o(fifo_out_data),
      .level_o()
   );
   assign tx_ready_o = fifo_in_ready & spi_mode & transmitter_enable_i;

   // Half-bit tick from shared baud generator
   mspi_baud_gen #(
      .DIV_W(DIV_W)
   ) u_baud (
      .ref_clk_i(ref_clk_i),
      .rst_i(rst_i),
      .run_i(state_r != ST_IDLE),
      .divisor_i(divisor),
      .tick_o(tick)
   );

   // Input pin synchroniser
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         din_meta_r <= 1'b0;
         din_sync_r <= 1'b0;
      end else begin
         din_meta_r <= data_in_i;
         din_sync_r <= din_meta_r;
      end
   end

   // Mode bits tracked to detect a live change
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         cpol_r <= 1'b0;
         cpha_r <= 1'b0;
      end else begin
         cpol_r <= clock_polarity_select_i;
         cpha_r <= clock_phase_select_i;
      end
   end
   // Mode change not guarded; takes effect at once
   assign mode_changed = (cpol_r != clock_polarity_select_i) | (cpha_r != clock_phase_select_i);

   // Next bit to drive, order shared with receiver
   assign out_bit = bit_order_select_i ? tx_shift_r[0] : tx_shift_r[7];
   assign frame_done = (state_r == ST_TRAIL) & tick & (bit_cnt_r == `MSPI_FRAME_BITS - 1'b1);
   assign fifo_pop = fifo_out_valid & spi_mode & transmitter_enable_i &
                     ((state_r == ST_IDLE) | frame_done);
   assign busy_o = (state_r != ST_IDLE);

   // State sequencing
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (fifo_pop) begin
               state_nxt = ST_LEAD;
            end
         end
         ST_LEAD: begin
            if (tick) begin
               state_nxt = ST_TRAIL;
            end
         end
         ST_TRAIL: begin
            if (tick) begin
               state_nxt = (frame_done && !fifo_pop) ? ST_IDLE : ST_LEAD;
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (!spi_mode || !transmitter_enable_i) begin
         state_nxt = ST_IDLE;
      end
   end

   // Single transfer controller: clock, shift out, sample in
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r <= ST_IDLE;
         tx_shift_r <= 8'h00;
         rx_shift_r <= 8'h00;
         bit_cnt_r <= {`MSPI_BITCNT_W{1'b0}};
         transfer_clock_pin_o <= 1'b0;
         data_out_o <= `MSPI_IDLE_LINE;
      end else begin
         state_r <= state_nxt;
         if (fifo_pop) begin
            // Load frame; phase 0 presents first bit before leading edge
            tx_shift_r <= fifo_out_data;
            bit_cnt_r <= {`MSPI_BITCNT_W{1'b0}};
            transfer_clock_pin_o <= clock_polarity_select_i;
            if (!clock_phase_select_i) begin
               data_out_o <= bit_order_select_i ? fifo_out_data[0] : fifo_out_data[7];
            end
         end else if (state_r == ST_LEAD && tick) begin
            // Leading edge
            transfer_clock_pin_o <= ~clock_polarity_select_i;
            if (clock_phase_select_i) begin
               data_out_o <= out_bit;
            end else begin
               rx_shift_r <= bit_order_select_i ? {din_sync_r, rx_shift_r[7:1]}
                                                : {rx_shift_r[6:0], din_sync_r};
            end
         end else if (state_r == ST_TRAIL && tick) begin
            // Trailing edge
            transfer_clock_pin_o <= clock_polarity_select_i;
            bit_cnt_r <= bit_cnt_r + 1'b1;
            tx_shift_r <= bit_order_select_i ? {1'b0, tx_shift_r[7:1]} : {tx_shift_r[6:0], 1'b0};
            if (clock_phase_select_i) begin
               rx_shift_r <= bit_order_select_i ? {din_sync_r, rx_shift_r[7:1]}
                                                : {rx_shift_r[6:0], din_sync_r};
            end else if (!frame_done) begin
               data_out_o <= bit_order_select_i ? tx_shift_r[1] : tx_shift_r[6];
            end
            if (frame_done) begin
               data_out_o <= `MSPI_IDLE_LINE;
            end
         end else if (state_r == ST_IDLE) begin
            transfer_clock_pin_o <= clock_polarity_select_i;
            data_out_o <= `MSPI_IDLE_LINE;
         end
      end
   end

   // Completed receive byte; mode-1/3 last sample lands at frame end
   assign rx_push = frame_done & receiver_enable_i;
   wire [7:0] rx_word;
   assign rx_word = clock_phase_select_i ?
                    (bit_order_select_i ? {din_sync_r, rx_shift_r[7:1]} : {rx_shift_r[6:0], din_sync_r})
                    : rx_shift_r;

   // Two-level receive buffer; newest byte dropped when full
   always @(posedge ref_clk_i) begin
      if (rst_i || !receiver_enable_i) begin
         rx_data_o <= 8'h00;
         rx_valid_r <= 1'b0;
         rx_hold_r <= 8'h00;
         rx_hold_valid_r <= 1'b0;
      end else begin
         if (rx_read_i && rx_valid_r) begin
            rx_data_o <= rx_hold_r;
            rx_valid_r <= rx_hold_valid_r;
            rx_hold_valid_r <= 1'b0;
            if (rx_push) begin
               if (rx_hold_valid_r) begin
                  rx_hold_r <= rx_word;
                  rx_hold_valid_r <= 1'b1;
               end else begin
                  rx_data_o <= rx_word;
                  rx_valid_r <= 1'b1;
               end
            end
         end else if (rx_push) begin
            if (!rx_valid_r) begin
               rx_data_o <= rx_word;
               rx_valid_r <= 1'b1;
            end else if (!rx_hold_valid_r) begin
               rx_hold_r <= rx_word;
               rx_hold_valid_r <= 1'b1;
            end
            // Both full: incoming byte discarded
         end
      end
   end
   assign rx_valid_o = rx_valid_r;

   // Transmit complete: set on last frame end, cleared by a new write
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         tx_complete_o <= 1'b0;
      end else if (frame_done && !fifo_pop) begin
         tx_complete_o <= 1'b1;
      end else if (tx_write_i && tx_ready_o) begin
         tx_complete_o <= 1'b0;
      end
   end

   // Mode change during a frame is tolerated but corrupts it
   wire unused_mode_change;
   assign unused_mode_change = mode_changed;
endmodule

/* tb/spi_slave_model.sv */
// Purpose: behavioural SPI slave on the far side of the master
// Assumes: no chip select; arm_i pulses only while the bus is idle
// Notes: echoes each received byte back in the following frame
`timescale 1ns/1ps
module spi_slave_model (
   // Setup
   input wire arm_i,
   input wire pol_i,
   input wire pha_i,
   input wire lsb_i,
   input wire [7:0] reply_i,
   // Serial lines
   input wire sclk_i,
   input wire mosi_i,
   output reg miso_o,
   // Last byte taken in
   output reg [7:0] got_o
);
   reg [7:0] out_r;
   reg [2:0] n_in;
   reg [2:0] n_out;
   // Bit k of the outgoing byte in the chosen order
   function bit_at(input [2:0] k);
      bit_at = lsb_i ? out_r[k] : out_r[3'd7 - k];
   endfunction
   initial begin
      miso_o = 1'b0;
      got_o = 8'h00;
      out_r = 8'h00;
      n_in = 3'd0;
      n_out = 3'd0;
   end
   // Load reply; phase 0 needs the first bit before the first edge
   always @(posedge arm_i) begin
      out_r = reply_i;
      n_in = 3'd0;
      n_out = {2'b00, !pha_i};
      miso_o = pha_i ? ~miso_o : bit_at(3'd0);
   end
   // Sample on one clock edge, set up on the other
   always @(sclk_i) begin
      if ((sclk_i != pol_i) ^ pha_i) begin
         got_o = lsb_i ? {mosi_i, got_o[7:1]} : {got_o[6:0], mosi_i};
         n_in = n_in + 3'd1;
         if (n_in == 3'd0) begin
            out_r = got_o;
            if (pha_i) miso_o = ~miso_o; // Released line does not hold its value
         end
      end else begin
         miso_o = bit_at(n_out);
         n_out = n_out + 3'd1;
      end
   end
endmodule

/* tb/mspi_master_asserts.sv */
// Purpose: port-level assertions for the SPI master
// Assumes: single clock domain, synchronous reset
// Notes: bound into every mspi_master instance
`timescale 1ns/1ps
module mspi_master_asserts (
   // Clock and reset
   input logic ref_clk_i,
   input logic rst_i,
   // Configuration
   input logic [1:0] operating_mode_select_i,
   input logic transmitter_enable_i,
   input logic clock_pin_direction_i,
   input logic clock_polarity_select_i,
   input logic [3:0] baud_divisor_high_i,
   input logic [7:0] baud_divisor_low_i,
   // Write side and status
   input logic tx_write_i,
   input logic tx_ready_o,
   input logic busy_o,
   input logic master_serial_peripheral_mode_o,
   input logic framing_error_flag_o,
   input logic overrun_flag_o,
   input logic parity_error_flag_o,
   // Serial pins
   input logic transfer_clock_pin_o,
   input logic transfer_clock_pin_oe_o,
   input logic data_out_o
);
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   reg [12:0] gap_r;
   reg armed_r;
   wire [12:0] half_w;
   assign half_w = {1'b0, baud_divisor_high_i, baud_divisor_low_i} + 13'h0001;
   // Cycles since the last clock pin change inside a frame
   always @(posedge ref_clk_i) begin
      if (rst_i || !busy_o) begin
         gap_r <= 13'h0001;
         armed_r <= 1'b0;
      end else if ($changed(transfer_clock_pin_o)) begin
         gap_r <= 13'h0001;
         armed_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 13'h0001;
      end
   end
   property p_mode; master_serial_peripheral_mode_o == (operating_mode_select_i == 2'h3); endproperty
   a_mode: assert property (p_mode) else $error("mode decode wrong");
   property p_refuse; (!transmitter_enable_i || operating_mode_select_i != 2'h3) |-> !tx_ready_o; endproperty
   a_refuse: assert property (p_refuse) else $error("write accepted while off");
   property p_oe; transfer_clock_pin_oe_o == (master_serial_peripheral_mode_o && clock_pin_direction_i); endproperty
   a_oe: assert property (p_oe) else $error("clock pin enable wrong");
   property p_flags; !(framing_error_flag_o || overrun_flag_o || parity_error_flag_o); endproperty
   a_flags: assert property (p_flags) else $error("error flag set");
   // Queue registers the byte, controller pops it next cycle, busy follows
   property p_start; tx_write_i && tx_ready_o && !busy_o |-> ##2 busy_o; endproperty
   a_start: assert property (p_start) else $error("frame did not start");
   property p_cause; $rose(busy_o) |-> $past(tx_write_i && tx_ready_o, 2); endproperty
   a_cause: assert property (p_cause) else $error("frame without write or gap");
   property p_clk_idle; !busy_o && $past(!busy_o) && !$past(rst_i) && $stable(clock_polarity_select_i)
      |-> transfer_clock_pin_o == clock_polarity_select_i; endproperty
   a_clk_idle: assert property (p_clk_idle) else $error("clock idle level wrong");
   property p_data_idle; !busy_o && $past(!busy_o) && !$past(rst_i) |-> data_out_o; endproperty
   a_data_idle: assert property (p_data_idle) else $error("data line not idle high");
   property p_rate; busy_o && armed_r && $changed(transfer_clock_pin_o) |-> gap_r == half_w; endproperty
   a_rate: assert property (p_rate) else $error("half bit length wrong");
endmodule
bind mspi_master mspi_master_asserts u_chk (
   .ref_clk_i, .rst_i, .operating_mode_select_i, .transmitter_enable_i, .clock_pin_direction_i,
   .clock_polarity_select_i, .baud_divisor_high_i, .baud_divisor_low_i, .tx_write_i, .tx_ready_o,
   .busy_o, .master_serial_peripheral_mode_o, .framing_error_flag_o, .overrun_flag_o,
   .parity_error_flag_o, .transfer_clock_pin_o, .transfer_clock_pin_oe_o, .data_out_o
);

/* tb/tb_usart_master_spi_mode.sv */
// Purpose: self-checking bench for the SPI master
// Assumes: 20 MHz clock, inputs driven at the falling edge
// Notes: slave model echoes the previous byte back
`timescale 1ns/1ps
module tb_usart_master_spi_mode;
   reg clk, rst, tx_en, dir, pol, pha, lsb, wr, rd, arm;
   reg [1:0] mode;
   reg [11:0] div;
   reg [7:0] wd, rep;
   wire [7:0] rx_data, got;
   wire tx_ready, rx_valid, msp, txc, fe, ovr, pe, busy, sck, sck_oe, dout, dout_oe, din;
   reg [31:0] rows [0:4];
   reg [2:0] m;
   reg [11:0] d;
   reg [7:0] t, y;
   reg c;
   integer n_mismatch, total_checks, i, n;
   mspi_master dut (.ref_clk_i(clk), .rst_i(rst), .operating_mode_select_i(mode), .transmitter_enable_i(tx_en),
      .receiver_enable_i(1'b1), .clock_pin_direction_i(dir), .clock_polarity_select_i(pol),
      .clock_phase_select_i(pha), .bit_order_select_i(lsb), .baud_divisor_high_i(div[11:8]),
      .baud_divisor_low_i(div[7:0]), .tx_write_i(wr), .tx_data_i(wd), .tx_ready_o(tx_ready), .rx_read_i(rd),
      .rx_data_o(rx_data), .rx_valid_o(rx_valid), .master_serial_peripheral_mode_o(msp), .tx_complete_o(txc),
      .framing_error_flag_o(fe), .overrun_flag_o(ovr), .parity_error_flag_o(pe), .busy_o(busy),
      .transfer_clock_pin_o(sck), .transfer_clock_pin_oe_o(sck_oe), .data_out_o(dout),
      .data_out_oe_o(dout_oe), .data_in_i(din));
   spi_slave_model slave (.arm_i(arm), .pol_i(pol), .pha_i(pha), .lsb_i(lsb), .reply_i(rep),
      .sclk_i(sck), .mosi_i(dout), .miso_o(din), .got_o(got));
   // Clock
   always #25 clk = ~clk;
   // Compare and count
   task chk(input [7:0] seen, input [7:0] exp);
      total_checks = total_checks + 1;
      if (seen !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Mode, order, divisor, then arm the slave; only called while idle
   task cfg(input p, input h, input l, input [11:0] dv, input [7:0] r);
      @(negedge clk);
      pol = p; pha = h; lsb = l; div = dv; rep = r;
      repeat (3) @(negedge clk);
      arm = 1'b1;
      @(negedge clk);
      arm = 1'b0;
   endtask
   task wr1(input [7:0] v);
      @(negedge clk);
      wr = 1'b1; wd = v;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task pop;
      @(negedge clk);
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
   endtask
   // Wait for all queued frames to finish
   task done;
      for (i = 0; i < 20000 && txc !== 1'b1; i = i + 1) @(negedge clk);
      repeat (3) @(negedge clk);
      chk(busy, 8'h00);
   endtask
   // Watchdog
   initial begin
      #2000000;
      n_mismatch = n_mismatch + 1;
      wrap_up;
   end
   initial begin
      // Clock pin set as output before any transfer
      clk = 0; rst = 1; mode = 2'h3; tx_en = 1; dir = 1; pol = 0; pha = 0; lsb = 0; div = 12'h000;
      wr = 0; rd = 0; arm = 0; wd = 8'h00; rep = 8'h00; n_mismatch = 0; total_checks = 0;
      rows[0] = {3'b000, 12'h002, 8'hA5, 8'h3C, 1'b1};
      rows[1] = {3'b011, 12'h003, 8'h81, 8'hC3, 1'b1};
      rows[2] = {3'b101, 12'h100, 8'h5A, 8'h96, 1'b1};
      rows[3] = {3'b110, 12'h002, 8'h0F, 8'hE1, 1'b1};
      rows[4] = {3'b001, 12'h000, 8'h37, 8'h00, 1'b0};
      repeat (5) @(negedge clk);
      rst = 0;
      // One frame per row in every mode and order
      for (n = 0; n < 5; n = n + 1) begin
         {m, d, t, y, c} = rows[n];
         cfg(m[2], m[1], m[0], d, y);
         wr1(t);
         done;
         chk(got, t);
         chk(txc, 8'h01);
         if (c) begin
            chk(rx_valid, 8'h01);
            chk(rx_data, y);
         end
         pop;
         $display("row %0d done", n);
      end
      // Fill the queue until refused, then check overflow keeps oldest
      cfg(0, 0, 0, 12'h002, 8'h11);
      n = 0;
      wr = 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         wd = 8'h40 + i[7:0];
         if (tx_ready === 1'b1) n = n + 1;
         @(negedge clk);
      end
      wr = 1'b0;
      chk(n[7:0], 8'h05);
      done;
      chk(got, 8'h44);
      chk(rx_data, 8'h11);
      pop;
      chk(rx_data, 8'h40);
      pop;
      chk(rx_valid, 8'h00);
      $display("queue test done");
      // Other mode selects and a disabled transmitter refuse writes
      for (m = 0; m < 3; m = m + 1) begin
         mode = m[1:0];
         @(negedge clk);
         chk({msp, tx_ready, sck_oe, dout_oe}, 8'h00);
      end
      mode = 2'h3;
      tx_en = 1'b0;
      wr1(8'hFF);
      repeat (20) @(negedge clk);
      chk(busy, 8'h00);
      chk(tx_ready, 8'h00);
      chk(got, 8'h44);
      chk({fe, ovr, pe}, 8'h00);
      tx_en = 1'b1;
      $display("refusal test done");
      // Reset in mid-frame returns pins to idle
      wr1(8'hAA);
      repeat (10) @(negedge clk);
      chk(busy, 8'h01);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk({sck, dout, rx_valid, txc}, 8'h04);
      rst = 1'b0;
      $display("reset test done");
      wrap_up;
   end
endmodule
